// ---- core/cie_pkg.sv ----
package cie_pkg;
   // ------------------------------------------------------------
   // Widths and map
   // ------------------------------------------------------------
   localparam int unsigned CIE_NUM_SRC = 8;
   localparam int unsigned CIE_VEC_W = 3;
   localparam logic [15:0] CIE_VEC_TOP = 16'hFFFE;
   localparam logic [15:0] CIE_SP_RST = 16'h00FF;
   localparam int unsigned CIE_VEC_BYTES = 2;
   localparam int unsigned CIE_STACK_BYTES = 6;
   localparam int unsigned CIE_MASK_BIT = 3;
   localparam logic [7:0] CIE_CC_RST = 8'h08;

   typedef enum logic [1:0] {
      CIE_OP_NONE,
      CIE_OP_CLI,
      CIE_OP_SEI,
      CIE_OP_RTI
   } cie_op_e;

   // Core register image stacked on entry
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] idx_hi;
      logic [7:0] idx_lo;
      logic [7:0] acc;
      logic [7:0] cc;
   } cie_regs_s;

   // Memory access request
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cie_mem_s;
endpackage : cie_pkg

// ---- core/cie_arbiter.sv ----
`timescale 1ns/10ps
module cie_arbiter #(
   parameter int unsigned N = cie_pkg::CIE_NUM_SRC,
   parameter int unsigned W = cie_pkg::CIE_VEC_W
) (
   input wire logic [N-1:0] req,
   output logic any,
   output logic [W-1:0] win
);
   import cie_pkg::*;
   logic [N-1:0] hit;
   logic [N-1:0] below;

   // ------------------------------------------------------------
   // Lowest index wins
   // ------------------------------------------------------------
   // fixed number priority
   assign below[0] = 1'b0;
   genvar g;
   generate
      for (g = 1; g < N; g++) begin : g_pri
         assign below[g] = below[g-1] | req[g-1];
      end
   endgenerate
   assign hit = req & ~below;
   assign any = |req;

   always_comb begin
      win = '0;
      for (int i = 0; i < N; i++) begin
         if (hit[i]) begin
            win = W'(i);
         end
      end
   end
endmodule : cie_arbiter

// ---- core/cie_entry.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Larger vector number means lower priority
// - Reset is highest, vector zero
// - Vector entry holds handler address
// - Check pending requests after each instruction other than CLI, SEI and RTI
// - Highest priority pending request served first
// - Acceptance sets the global mask
// - Handler completion clears mask again
// - Finish current instruction before entry
// - Push PC, index pair, accumulator, condition codes
// - Fetch winning vector, load PC, run
// - Two-byte vectors at top of memory
// - Mask bit in condition codes blocks all
// - Any reset leaves mask set
module cie_entry (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [cie_pkg::CIE_NUM_SRC-1:1] irq_req,
   input wire logic instr_done,
   input wire cie_pkg::cie_op_e op,
   input wire cie_pkg::cie_regs_s core_regs,
   output cie_pkg::cie_mem_s mem_req,
   input wire logic [7:0] mem_rdata,
   output logic core_hold,
   output logic load_valid,
   output cie_pkg::cie_regs_s load_regs,
   output logic [15:0] sp,
   output logic mask,
   output logic [cie_pkg::CIE_VEC_W-1:0] vec_num
);
   import cie_pkg::*;

   typedef enum {
      S_RUN,
      S_PUSH,
      S_VEC_HI,
      S_VEC_LO,
      S_POP
   } cie_state_e;

   cie_state_e state_q;
   logic [2:0] cnt_q;
   logic [15:0] sp_q;
   logic [7:0] cc_q;
   logic [CIE_VEC_W-1:0] vec_q;
   logic [15:0] pc_q;
   cie_regs_s save_q;
   cie_regs_s pop_q;
   logic first_q;
   logic load_q;
   logic [CIE_NUM_SRC-1:0] req_all;
   logic any;
   logic [CIE_VEC_W-1:0] win;
   logic take;
   logic [15:0] vec_addr;
   logic [7:0] push_byte;

   // ------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------
   // vector zero is reset
   assign req_all = {irq_req, 1'b0};
   cie_arbiter #(.N(CIE_NUM_SRC), .W(CIE_VEC_W)) u_arb (
      .req(req_all),
      .any(any),
      .win(win)
   );

   assign take = (state_q == S_RUN) && instr_done && any && !cc_q[CIE_MASK_BIT]
      && (op == CIE_OP_NONE);

   assign vec_addr = CIE_VEC_TOP - 16'(CIE_VEC_BYTES * vec_q);

   // Push order: PCL, PCH, X lo, X hi, A, CC, so pop reverses to CC first
   always_comb begin
      unique case (cnt_q)
         3'd0: push_byte = save_q.pc[7:0];
         3'd1: push_byte = save_q.pc[15:8];
         3'd2: push_byte = save_q.idx_lo;
         3'd3: push_byte = save_q.idx_hi;
         3'd4: push_byte = save_q.acc;
         default: push_byte = save_q.cc;
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= S_RUN;
         cnt_q <= 3'd0;
      end else begin
         unique case (state_q)
            S_RUN: begin
               cnt_q <= 3'd0;
               if (take) begin
                  state_q <= S_PUSH;
               end else if (instr_done && op == CIE_OP_RTI) begin
                  state_q <= S_POP;
               end
            end
            S_PUSH: begin
               cnt_q <= cnt_q + 3'd1;
               if (cnt_q == 3'(CIE_STACK_BYTES - 1)) begin
                  state_q <= S_VEC_HI;
               end
            end
            S_VEC_HI: state_q <= S_VEC_LO;
            S_VEC_LO: state_q <= S_RUN;
            S_POP: begin
               cnt_q <= cnt_q + 3'd1;
               if (cnt_q == 3'(CIE_STACK_BYTES - 1)) begin
                  state_q <= S_RUN;
               end
            end
         endcase
      end
   end

   // Push writes at sp then decrements; pop increments then reads
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sp_q <= CIE_SP_RST;
      end else if (state_q == S_PUSH) begin
         sp_q <= sp_q - 16'd1;
      end else if (state_q == S_POP) begin
         sp_q <= sp_q + 16'd1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         save_q <= '0;
         vec_q <= '0;
      end else if (take) begin
         save_q <= core_regs;
         vec_q <= win;
      end
   end

   // ------------------------------------------------------------
   // Global mask
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cc_q <= CIE_CC_RST;
      end else if (state_q == S_RUN && instr_done && op != CIE_OP_NONE) begin
         cc_q <= core_regs.cc;
         if (op == CIE_OP_CLI) begin
            cc_q[CIE_MASK_BIT] <= 1'b0;
         end else if (op == CIE_OP_SEI) begin
            cc_q[CIE_MASK_BIT] <= 1'b1;
         end
      end else if (take) begin
         cc_q <= core_regs.cc | 8'(1 << CIE_MASK_BIT);
      end else if (state_q == S_POP && cnt_q == 3'd0) begin
         cc_q <= mem_rdata;
      end else if (state_q == S_RUN) begin
         cc_q <= core_regs.cc | (cc_q & 8'(1 << CIE_MASK_BIT));
      end
   end

   // ------------------------------------------------------------
   // Restore path
   // ------------------------------------------------------------
   // Memory read data is taken in the same cycle as the address
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pc_q <= '0;
         pop_q <= '0;
         load_q <= 1'b0;
      end else begin
         load_q <= 1'b0;
         if (state_q == S_VEC_HI) begin
            pc_q[15:8] <= mem_rdata;
         end
         if (state_q == S_VEC_LO) begin
            pc_q[7:0] <= mem_rdata;
            pop_q <= save_q;
            pop_q.pc <= {pc_q[15:8], mem_rdata};
            pop_q.cc <= cc_q;
            load_q <= 1'b1;
         end
         if (state_q == S_POP) begin
            unique case (cnt_q)
               3'd0: pop_q.cc <= mem_rdata;
               3'd1: pop_q.acc <= mem_rdata;
               3'd2: pop_q.idx_hi <= mem_rdata;
               3'd3: pop_q.idx_lo <= mem_rdata;
               3'd4: pop_q.pc[15:8] <= mem_rdata;
               default: begin
                  pop_q.pc[7:0] <= mem_rdata;
                  load_q <= 1'b1;
               end
            endcase
         end
      end
   end

   always_comb begin
      mem_req = '0;
      unique case (state_q)
         S_PUSH: begin
            mem_req.valid = 1'b1;
            mem_req.write = 1'b1;
            mem_req.addr = sp_q;
            mem_req.wdata = push_byte;
         end
         S_VEC_HI: begin
            mem_req.valid = 1'b1;
            mem_req.addr = vec_addr - 16'd1;
         end
         S_VEC_LO: begin
            mem_req.valid = 1'b1;
            mem_req.addr = vec_addr;
         end
         S_POP: begin
            mem_req.valid = 1'b1;
            mem_req.addr = sp_q + 16'd1;
         end
         default: mem_req = '0;
      endcase
   end

   assign core_hold = (state_q != S_RUN) || take;
   assign load_valid = load_q;
   assign load_regs = pop_q;
   assign sp = sp_q;
   assign mask = cc_q[CIE_MASK_BIT];
   assign vec_num = vec_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_mask_on_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take |=> mask) else $error("mask not set on entry");
   chk_no_take_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == S_RUN && mask |=> !mem_req.write) else $error("taken while masked");
   chk_boundary_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !core_hold && !instr_done |=> !mem_req.valid) else $error("entry mid instruction");
   chk_push_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take |=> mem_req.write [*6] ##1 !mem_req.write) else $error("bad push length");
   chk_vec_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take |-> ##9 load_valid) else $error("vector not loaded");
   chk_prio_win: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take && req_all[1] |=> vec_num == 3'd1) else $error("priority lost");
   chk_rst_mask: assert property (@(posedge clk_sys)
      !rst_n |=> mask) else $error("mask clear after reset");
   chk_vec_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == S_VEC_LO |-> mem_req.addr == CIE_VEC_TOP - 16'(2 * vec_num))
      else $error("bad vector address");
   chk_rti_restore: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == S_RUN && instr_done && op == CIE_OP_RTI |-> ##7 load_valid)
      else $error("return restore late");
endmodule : cie_entry

// ---- tb/cie_mem_model.sv ----
`timescale 1ns/10ps
module cie_mem_model (
   input wire logic clk_sys,
   input wire cie_pkg::cie_mem_s mem_req,
   output logic [7:0] mem_rdata
);
   import cie_pkg::*;
   logic [7:0] mem [0:65535];
   // ------------------------------------------------------------
   // Program memory with vector table at the top
   // ------------------------------------------------------------
   // handler address bytes
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end
   // Plain always: the preload above also writes the array
   always @(posedge clk_sys) begin
      if (mem_req.valid && mem_req.write) begin
         mem[mem_req.addr] <= mem_req.wdata;
      end
   end
   // Idle bus shows inverted data so a stale byte never looks valid
   assign mem_rdata = (mem_req.valid && !mem_req.write) ? mem[mem_req.addr] : ~mem[mem_req.addr];
endmodule : cie_mem_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
   import cie_pkg::*;
   logic clk_sys, rst_n, instr_done, core_hold, load_valid, mask;
   logic [CIE_NUM_SRC-1:1] irq_req;
   cie_op_e op;
   cie_regs_s core_regs, load_regs, saved;
   cie_mem_s mem_req;
   logic [7:0] mem_rdata;
   logic [15:0] sp;
   logic [CIE_VEC_W-1:0] vec_num;
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   cie_entry dut (.clk_sys(clk_sys), .rst_n(rst_n), .irq_req(irq_req),
      .instr_done(instr_done), .op(op), .core_regs(core_regs), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .core_hold(core_hold), .load_valid(load_valid),
      .load_regs(load_regs), .sp(sp), .mask(mask), .vec_num(vec_num));
   cie_mem_model mdl (.clk_sys(clk_sys), .mem_req(mem_req), .mem_rdata(mem_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Hang guard, a full run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 5000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   function automatic logic [15:0] vec_of(input int n);
      logic [15:0] hi, lo;
      hi = CIE_VEC_TOP - 16'(2 * n) - 16'h0001;
      lo = CIE_VEC_TOP - 16'(2 * n);
      return {hi[7:0] ^ 8'h5A, lo[7:0] ^ 8'h5A};
   endfunction : vec_of
   function automatic int top_src(input logic [CIE_NUM_SRC-1:1] r);
      for (int i = 1; i < CIE_NUM_SRC; i++) begin
         if (r[i]) return i;
      end
      return 0;
   endfunction : top_src
   // One instruction boundary, ends in the cycle after the boundary edge
   task automatic step(input cie_op_e o, input logic h);
      instr_done = 1'b1;
      op = o;
      #1 chk(16'(core_hold), 16'(h));
      @(negedge clk_sys);
      instr_done = 1'b0;
      op = CIE_OP_NONE;
   endtask : step
   task automatic take(input logic [CIE_NUM_SRC-1:1] r);
      logic [15:0] s;
      logic [7:0] b [CIE_STACK_BYTES];
      s = sp;
      irq_req = r;
      core_regs = cie_regs_s'(48'({$urandom(), $urandom()}));
      core_regs.cc[CIE_MASK_BIT] = 1'b0;
      saved = core_regs;
      b = '{saved.pc[7:0], saved.pc[15:8], saved.idx_lo, saved.idx_hi, saved.acc, saved.cc};
      step(CIE_OP_NONE, 1'b1);
      for (int k = 0; k < CIE_STACK_BYTES; k++) begin
         chk(16'({mem_req.valid, mem_req.write}), 16'h0003);
         chk(mem_req.addr, s - 16'(k));
         chk(16'(mem_req.wdata), 16'(b[k]));
         @(negedge clk_sys);
      end
      for (int k = 0; k < 2; k++) begin
         chk(16'({mem_req.valid, mem_req.write}), 16'h0002);
         chk(mem_req.addr, CIE_VEC_TOP - 16'(2 * top_src(r)) - 16'(1 - k));
         @(negedge clk_sys);
      end
      irq_req = '0;
      chk(16'(load_valid), 16'h0001);
      chk(load_regs.pc, vec_of(top_src(r)));
      chk(16'(vec_num), 16'(top_src(r)));
      chk(16'(mask), 16'h0001);
      chk(16'(load_regs.cc[CIE_MASK_BIT]), 16'h0001);
      chk(sp, s - 16'(CIE_STACK_BYTES));
      @(negedge clk_sys);
   endtask : take
   // Return boundary itself does not stall; the pops that follow do
   task automatic rti();
      step(CIE_OP_RTI, 1'b0);
      repeat (CIE_STACK_BYTES) @(negedge clk_sys);
      chk(16'(load_valid), 16'h0001);
      chk(load_regs.pc, saved.pc);
      chk({load_regs.acc, load_regs.cc}, {saved.acc, saved.cc});
      chk({load_regs.idx_hi, load_regs.idx_lo}, {saved.idx_hi, saved.idx_lo});
      @(negedge clk_sys);
      chk(16'(mask), 16'h0000);
      chk(sp, CIE_SP_RST);
   endtask : rti
   initial begin
      rst_n = 1'b0;
      instr_done = 1'b0;
      op = CIE_OP_NONE;
      irq_req = '0;
      core_regs = '0;
      void'($urandom(32'hea801832));
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      chk(16'(mask), 16'h0001);
      chk(sp, CIE_SP_RST);
      irq_req = '1;
      step(CIE_OP_NONE, 1'b0);
      // Handler-style unmask, pending requests wait for a boundary
      step(CIE_OP_CLI, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk(16'(core_hold), 16'h0000);
      chk(16'(mask), 16'h0000);
      $display("test reset_mask done");
      take('1);
      rti();
      take(7'h40);
      rti();
      for (int t = 0; t < 6; t++) begin
         take(7'($urandom_range(1, 127)));
         rti();
      end
      $display("test entry_return done");
      step(CIE_OP_SEI, 1'b0);
      chk(16'(mask), 16'h0001);
      irq_req = 7'h05;
      step(CIE_OP_NONE, 1'b0);
      rst_n = 1'b0;
      step(CIE_OP_CLI, 1'b0);
      rst_n = 1'b1;
      chk(16'(mask), 16'h0001);
      $display("test sei_reset done");
      print_verdict();
   end
endmodule : tb
